// >>> hdl/ircg_top.sv
// Chosen here: the register offsets and register access over AXI4-Lite.
`timescale 1ns/100ps
module ircg_top
  import ircg_pkg::*;
(
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic irq,
  output logic carrier_out_pin
);

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  logic aw_held_q, w_held_q, wstrb0_q;
  logic [ADDR_W-1:0] awaddr_q;
  logic [7:0] wdata_q;
  logic bvalid_q, rvalid_q;
  logic [1:0] bresp_q, rresp_q;
  logic [31:0] rdata_q;
  logic wr_fire, wr_hit, wr_byte;
  logic carrier_timer_enable_q, pulse_count_timer_enable_q, remote_output_enable_q;
  logic [7:0] low_width_compare_q, high_wr_q, high_act_q;
  logic high_pend_q;
  logic [1:0] high_age_q;
  logic carrier_enable_buffer_q, carrier_enable_master_q;
  logic [2:0] pulse_count_clock_select_q;
  logic [7:0] pulse_count_compare_q;
  logic [IRQ_W-1:0] status_q, irq_en_q, status_set;
  logic [7:0] cnt_q, cmp_val;
  logic sel_high_q, carrier_q, gate_q, out_q;
  logic carrier_timer_match_irq, high_match, high_apply;
  logic carrier_d, gate_d;
  logic pulse_count_match_irq, synced_transfer_strobe;
  logic [7:0] pulse_count_counter;
  logic [31:0] rdata_d;
  logic rd_hit;

  // ----------------------------------------
  // AXI4-Lite write channel
  // ----------------------------------------

  // Address and data are taken in either order and held until the response.
  assign s_axi_awready = ~aw_held_q & ~bvalid_q;
  assign s_axi_wready = ~w_held_q & ~bvalid_q;
  assign wr_fire = aw_held_q & w_held_q & ~bvalid_q;
  assign wr_byte = wr_fire & wstrb0_q;

  // Capture of the write address and data.
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      awaddr_q <= '0;
      wdata_q <= '0;
      wstrb0_q <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end else if (wr_fire) begin
        aw_held_q <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_q <= 1'b1;
        wdata_q <= s_axi_wdata[7:0];
        wstrb0_q <= s_axi_wstrb[0];
      end else if (wr_fire) begin
        w_held_q <= 1'b0;
      end
    end
  end

  // Decodes whether the write address names a register.
  always_comb begin
    unique case ({awaddr_q[ADDR_W-1:2], 2'b00})
      OFS_CTRL, OFS_LOW_CMP, OFS_HIGH_CMP, OFS_CARRIER, OFS_PC_SEL,
      OFS_PC_CMP, OFS_STATUS, OFS_IRQ_EN, OFS_IRQ_CLR, OFS_COUNT: wr_hit = 1'b1;
      default: wr_hit = 1'b0;
    endcase
  end

  // Write response, an error for an unmapped address.
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_q <= 1'b1;
      bresp_q <= wr_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_q <= 1'b0;
    end
  end

  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;

  // ----------------------------------------
  // Software registers
  // ----------------------------------------

  // Control bits and the compare registers that are applied at once.
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      carrier_timer_enable_q <= 1'b0;
      pulse_count_timer_enable_q <= 1'b0;
      remote_output_enable_q <= 1'b0;
      low_width_compare_q <= CMP_RST;
      pulse_count_clock_select_q <= PCSEL_RST;
      pulse_count_compare_q <= CMP_RST;
      carrier_enable_buffer_q <= 1'b0;
      irq_en_q <= '0;
    end else if (wr_byte) begin
      unique case (awaddr_q)
        OFS_CTRL: begin
          carrier_timer_enable_q <= wdata_q[CTRL_CTE];
          pulse_count_timer_enable_q <= wdata_q[CTRL_PTE];
          remote_output_enable_q <= wdata_q[CTRL_RMT];
        end
        OFS_LOW_CMP: low_width_compare_q <= wdata_q; // Must not change while running.
        OFS_PC_SEL: pulse_count_clock_select_q <= wdata_q[2:0];
        OFS_PC_CMP: pulse_count_compare_q <= wdata_q;
        OFS_CARRIER: carrier_enable_buffer_q <= wdata_q[CARR_BUF];
        OFS_IRQ_EN: irq_en_q <= wdata_q[IRQ_W-1:0];
        default: ;
      endcase
    end
  end

  // The high compare is latched and moved to the active copy on a safe match.
  assign high_match = carrier_timer_match_irq & sel_high_q;
  assign high_apply = high_pend_q &
    (~carrier_timer_enable_q | (high_match & (high_age_q == AGE_MIN)));

  // Pending high compare value and its age in count clocks.
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      high_wr_q <= CMP_RST;
      high_act_q <= CMP_RST;
      high_pend_q <= 1'b0;
      high_age_q <= '0;
    end else if (wr_byte && awaddr_q == OFS_HIGH_CMP) begin
      high_wr_q <= wdata_q;
      high_pend_q <= 1'b1;
      high_age_q <= '0;
    end else begin
      if (high_pend_q && high_age_q != AGE_MIN) begin
        high_age_q <= high_age_q + 2'h1;
      end
      if (high_apply) begin
        high_act_q <= high_wr_q;
        high_pend_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Carrier timer
  // ----------------------------------------

  // The active compare alternates between the low and high widths.
  assign cmp_val = sel_high_q ? high_act_q : low_width_compare_q;
  assign carrier_timer_match_irq = carrier_timer_enable_q & (cnt_q == cmp_val);

  // Counter runs only while enabled and restarts from zero on each match.
  always_ff @(posedge clock) begin
    if (sys_rst || !carrier_timer_enable_q) begin
      cnt_q <= '0;
      sel_high_q <= 1'b0;
    end else if (carrier_timer_match_irq) begin
      cnt_q <= '0;
      sel_high_q <= ~sel_high_q;
    end else begin
      cnt_q <= cnt_q + 8'h01;
    end
  end

  // Carrier is low by default and inverts on every compare match.
  always_comb begin
    if (!carrier_timer_enable_q) begin
      carrier_d = 1'b0;
    end else if (carrier_timer_match_irq) begin
      carrier_d = ~carrier_q;
    end else begin
      carrier_d = carrier_q;
    end
  end

  // The gate takes the master on a carrier rise, closes while the carrier is low and the master clear, or at once when remote output or timer is disabled.
  always_comb begin
    if (!remote_output_enable_q || !carrier_timer_enable_q) begin
      gate_d = 1'b0;
    end else if (carrier_d && !carrier_q) begin
      gate_d = carrier_enable_master_q;
    end else if (!carrier_d) begin
      gate_d = gate_q & carrier_enable_master_q;
    end else begin
      gate_d = gate_q;
    end
  end

  // Carrier, gate and the registered output pin.
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      carrier_q <= 1'b0;
      gate_q <= 1'b0;
      out_q <= 1'b0;
    end else begin
      carrier_q <= carrier_d;
      gate_q <= gate_d;
      out_q <= carrier_d & gate_d;
    end
  end

  assign carrier_out_pin = out_q;

  // ----------------------------------------
  // Pulse-count timer and transfer strobe
  // ----------------------------------------

  // Counts carrier cycles, emitted or gated, when its clock select names the carrier.
  ircg_pulse_timer #(
    .CNT_W(8)
  ) u_pulse_timer (
    .clock(clock),
    .sys_rst(sys_rst),
    .enable(pulse_count_timer_enable_q),
    .clock_select(pulse_count_clock_select_q),
    .compare(pulse_count_compare_q),
    .carrier_rise(carrier_d & ~carrier_q),
    .count_q(pulse_count_counter),
    .match_q(pulse_count_match_irq)
  );

  // Turns the match into the internal strobe on the count clock.
  ircg_strobe_sync u_strobe_sync (
    .clock(clock),
    .sys_rst(sys_rst),
    .event_in(pulse_count_match_irq),
    .strobe_q(synced_transfer_strobe)
  );

  // Master enable follows the buffer one clock after the strobe rises.
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      carrier_enable_master_q <= 1'b0;
    end else if (synced_transfer_strobe) begin
      carrier_enable_master_q <= carrier_enable_buffer_q;
    end
  end

  // ----------------------------------------
  // Interrupt status
  // ----------------------------------------

  // A new event wins over a clear in the same cycle; the strobe raises nothing.
  assign status_set = {pulse_count_match_irq, carrier_timer_match_irq};

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      status_q <= '0;
    end else if (wr_byte && awaddr_q == OFS_IRQ_CLR) begin
      status_q <= (status_q & ~wdata_q[IRQ_W-1:0]) | status_set;
    end else begin
      status_q <= status_q | status_set;
    end
  end

  assign irq = |(status_q & irq_en_q);

  // ----------------------------------------
  // AXI4-Lite read channel
  // ----------------------------------------

  assign s_axi_arready = ~rvalid_q;

  // Read data selection; write-only and unmapped words read zero.
  always_comb begin
    rdata_d = '0;
    rd_hit = 1'b1;
    unique case ({s_axi_araddr[ADDR_W-1:2], 2'b00})
      OFS_CTRL: begin
        rdata_d[CTRL_CTE] = carrier_timer_enable_q;
        rdata_d[CTRL_PTE] = pulse_count_timer_enable_q;
        rdata_d[CTRL_RMT] = remote_output_enable_q;
      end
      OFS_LOW_CMP: rdata_d[7:0] = low_width_compare_q;
      OFS_HIGH_CMP: rdata_d[7:0] = high_wr_q;
      OFS_CARRIER: begin
        rdata_d[CARR_BUF] = carrier_enable_buffer_q;
        rdata_d[CARR_MST] = carrier_enable_master_q;
      end
      OFS_PC_SEL: rdata_d[2:0] = pulse_count_clock_select_q;
      OFS_PC_CMP: rdata_d[7:0] = pulse_count_compare_q;
      OFS_STATUS: rdata_d[IRQ_W-1:0] = status_q;
      OFS_IRQ_EN: rdata_d[IRQ_W-1:0] = irq_en_q;
      OFS_IRQ_CLR: ;
      OFS_COUNT: rdata_d[15:0] = {pulse_count_counter, cnt_q};
      default: rd_hit = 1'b0;
    endcase
  end

  // Read response register.
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      rvalid_q <= 1'b0;
      rdata_q <= '0;
      rresp_q <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_q <= 1'b1;
      rdata_q <= rdata_d;
      rresp_q <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------

  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);

  property p_halted;
    !carrier_timer_enable_q |=> cnt_q == 8'h00 && !carrier_q;
  endproperty
  a_halted: assert property (p_halted) else $error("Counter ran while disabled.");

  property p_start_default;
    $rose(carrier_timer_enable_q) |-> !carrier_q && !sel_high_q;
  endproperty
  a_start_default: assert property (p_start_default) else $error("Bad start state.");

  property p_low_match;
    carrier_timer_match_irq && !sel_high_q |=>
      cnt_q == 8'h00 && sel_high_q && carrier_q != $past(carrier_q) && status_q[IRQ_CARR];
  endproperty
  a_low_match: assert property (p_low_match) else $error("Low match misbehaved.");

  property p_high_match;
    carrier_timer_match_irq && sel_high_q |=>
      cnt_q == 8'h00 && !sel_high_q && carrier_q != $past(carrier_q) && status_q[IRQ_CARR];
  endproperty
  a_high_match: assert property (p_high_match) else $error("High match misbehaved.");

  property p_strobe;
    pulse_count_match_irq && !$past(pulse_count_match_irq) |=> synced_transfer_strobe;
  endproperty
  a_strobe: assert property (p_strobe) else $error("Missing transfer strobe.");

  property p_transfer;
    synced_transfer_strobe |=> carrier_enable_master_q == $past(carrier_enable_buffer_q);
  endproperty
  a_transfer: assert property (p_transfer) else $error("Master not loaded.");

  property p_master_steady;
    !synced_transfer_strobe |=> $stable(carrier_enable_master_q);
  endproperty
  a_master_steady: assert property (p_master_steady) else $error("Master moved.");

  property p_out_rise;
    $rose(out_q) |-> $rose(carrier_q) && $past(carrier_enable_master_q);
  endproperty
  a_out_rise: assert property (p_out_rise) else $error("Output rose off edge.");

  property p_full_high;
    out_q && remote_output_enable_q && carrier_timer_enable_q ##1 carrier_q
      |-> out_q;
  endproperty
  a_full_high: assert property (p_full_high) else $error("High pulse cut.");

  // The pin register follows the remote enable one clock late, so the enable's past value counts.
  property p_out_low;
    !carrier_q || !$past(remote_output_enable_q) |-> !out_q;
  endproperty
  a_out_low: assert property (p_out_low) else $error("Output high when off.");

  property p_high_defer;
    high_pend_q && high_match && high_age_q != AGE_MIN |=> high_act_q == $past(high_act_q);
  endproperty
  a_high_defer: assert property (p_high_defer) else $error("Early transfer.");

  // The carrier and pin registers see the cleared enable at the edge after it falls.
  property p_stop;
    $fell(carrier_timer_enable_q) |=> !carrier_q && !out_q && !sel_high_q;
  endproperty
  a_stop: assert property (p_stop) else $error("Stop did not reset.");

endmodule

// >>> hdl/ircg_pkg.sv
package ircg_pkg;

  // ----------------------------------------
  // Register map, byte addresses
  // ----------------------------------------
  localparam int ADDR_W = 6;
  localparam logic [5:0] OFS_CTRL = 6'h00;
  localparam logic [5:0] OFS_LOW_CMP = 6'h04;
  localparam logic [5:0] OFS_HIGH_CMP = 6'h08;
  localparam logic [5:0] OFS_CARRIER = 6'h0c;
  localparam logic [5:0] OFS_PC_SEL = 6'h10;
  localparam logic [5:0] OFS_PC_CMP = 6'h14;
  localparam logic [5:0] OFS_STATUS = 6'h18;
  localparam logic [5:0] OFS_IRQ_EN = 6'h1c;
  localparam logic [5:0] OFS_IRQ_CLR = 6'h20;
  localparam logic [5:0] OFS_COUNT = 6'h24;

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int CTRL_CTE = 0;
  localparam int CTRL_PTE = 1;
  localparam int CTRL_RMT = 2;
  localparam int CARR_BUF = 0;
  localparam int CARR_MST = 1;
  localparam int IRQ_CARR = 0;
  localparam int IRQ_PC = 1;
  localparam int IRQ_W = 2;

  // ----------------------------------------
  // Reset values and codes
  // ----------------------------------------
  localparam logic [7:0] CMP_RST = 8'h01;
  localparam logic [2:0] PCSEL_RST = 3'h0;
  localparam logic [2:0] PCSEL_CARRIER = 3'h7;
  localparam logic [1:0] AGE_MIN = 2'h3;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// >>> hdl/ircg_strobe_sync.sv
`timescale 1ns/100ps
module ircg_strobe_sync
  import ircg_pkg::*;
(
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic event_in,
  output logic strobe_q
);

  logic prev_q;

  // Registers the event on the count clock and keeps only its rising edge.
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      prev_q <= 1'b0;
      strobe_q <= 1'b0;
    end else begin
      prev_q <= event_in;
      strobe_q <= event_in & ~prev_q;
    end
  end

endmodule

// >>> hdl/ircg_pulse_timer.sv
`timescale 1ns/100ps
module ircg_pulse_timer
  import ircg_pkg::*;
#(
  parameter int CNT_W = 8
)
(
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic enable,
  input wire logic [2:0] clock_select,
  input wire logic [CNT_W-1:0] compare,
  input wire logic carrier_rise,
  output logic [CNT_W-1:0] count_q,
  output logic match_q
);

  logic tick;

  // The carrier code counts carrier cycles, emitted or gated, any other code every clock.
  assign tick = (clock_select == PCSEL_CARRIER) ? carrier_rise : 1'b1;

  // Counter clears on match, so a compare of K spans K+1 ticks.
  always_ff @(posedge clock) begin
    if (sys_rst || !enable) begin
      count_q <= '0;
      match_q <= 1'b0;
    end else begin
      match_q <= 1'b0;
      if (tick) begin
        if (count_q == compare) begin
          count_q <= '0;
          match_q <= 1'b1;
        end else begin
          count_q <= count_q + 1'b1;
        end
      end
    end
  end

endmodule

// >>> bench/ircg_led_model.sv
`timescale 1ns/100ps
module ircg_led_model (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic drive,
  output logic [15:0] pulse_count,
  output logic [15:0] high_width,
  output logic [15:0] low_width
);
  logic [15:0] run_q;
  logic last_q;

  // ----------------------------------------
  // Emitter stage
  // ----------------------------------------
  // The diode lights while the pin is high; each flash and each gap is timed in clocks.
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      run_q <= 16'h0001;
      last_q <= 1'b0;
      pulse_count <= 16'h0000;
      high_width <= 16'h0000;
      low_width <= 16'h0000;
    end else if (drive !== last_q) begin
      if (last_q) begin
        high_width <= run_q;
      end else begin
        low_width <= run_q;
      end
      if (drive) begin
        pulse_count <= pulse_count + 16'h0001;
      end
      last_q <= drive;
      run_q <= 16'h0001;
    end else begin
      run_q <= run_q + 16'h0001;
    end
  end
endmodule

// >>> bench/test_ircg_top.sv
`timescale 1ns/100ps
module test_ircg_top
  import ircg_pkg::*;
;
  localparam logic [31:0] LOW_N = 32'h3;
  localparam logic [31:0] HIGH_M = 32'h5;
  localparam logic [31:0] HIGH_L = 32'h9;
  localparam int TIME_CEIL = 40000;
  logic clock, sys_rst, irq, carrier_out_pin;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, d;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic [15:0] led_count, led_high, led_low, snap;
  int num_errors = 0;
  int num_checks = 0;
  int cycles = 0;
  logic [5:0] ra [8] = '{OFS_CTRL, OFS_LOW_CMP, OFS_HIGH_CMP, OFS_CARRIER, OFS_PC_SEL,
                         OFS_STATUS, OFS_IRQ_EN, OFS_IRQ_CLR};
  logic [31:0] rv [8] = '{32'h0, {24'h0, CMP_RST}, {24'h0, CMP_RST}, 32'h0, 32'h0, 32'h0,
                          32'h0, 32'h0};

  ircg_top u_dut (.clock(clock), .sys_rst(sys_rst), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .irq(irq), .carrier_out_pin(carrier_out_pin));

  ircg_led_model u_led (.clock(clock), .sys_rst(sys_rst), .drive(carrier_out_pin),
    .pulse_count(led_count), .high_width(led_high), .low_width(led_low));

  // ----------------------------------------
  // Clock, timeout and reporting
  // ----------------------------------------
  // Free running 50 MHz clock.
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  // A hang ends the run as a failure.
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == TIME_CEIL) begin
      num_errors++;
      stop_test();
    end
  end

  task automatic stop_test();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // ----------------------------------------
  // Register bus master
  // ----------------------------------------
  // Ready is looked at mid-cycle, so the edge that takes an item also releases it.
  task automatic wr(input logic [5:0] a, input logic [31:0] v, output logic [1:0] resp);
    logic aw_left, w_left, take_aw, take_w;
    aw_left = 1'b1;
    w_left = 1'b1;
    @(posedge clock);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= v;
    s_axi_wstrb <= 4'hf;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (aw_left || w_left) begin
      @(negedge clock);
      take_aw = aw_left && s_axi_awready === 1'b1;
      take_w = w_left && s_axi_wready === 1'b1;
      @(posedge clock);
      if (take_aw) begin
        s_axi_awvalid <= 1'b0;
        aw_left = 1'b0;
      end
      if (take_w) begin
        s_axi_wvalid <= 1'b0;
        w_left = 1'b0;
      end
    end
    do @(negedge clock); while (s_axi_bvalid !== 1'b1);
    resp = s_axi_bresp;
    @(posedge clock);
    s_axi_bready <= 1'b0;
  endtask

  task automatic put(input logic [5:0] a, input logic [31:0] v);
    logic [1:0] resp;
    wr(a, v, resp);
  endtask

  task automatic rd(input logic [5:0] a, output logic [31:0] v, output logic [1:0] resp);
    @(posedge clock);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(negedge clock); while (s_axi_arready !== 1'b1);
    @(posedge clock);
    s_axi_arvalid <= 1'b0;
    do @(negedge clock); while (s_axi_rvalid !== 1'b1);
    v = s_axi_rdata;
    resp = s_axi_rresp;
    @(posedge clock);
    s_axi_rready <= 1'b0;
  endtask

  // Polls one bit until it shows the wanted level.
  task automatic wait_bit(input logic [5:0] a, input int b, input logic v);
    logic [31:0] x;
    logic [1:0] resp;
    do rd(a, x, resp); while (x[b] !== v);
  endtask

  // ----------------------------------------
  // Test sequence
  // ----------------------------------------
  // Reset defaults, a steady carrier, a width change, gating, stop and a counted burst.
  initial begin
    sys_rst = 1'b1;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
    repeat (20) @(posedge clock);
    sys_rst <= 1'b0;
    for (int i = 0; i < 8; i++) begin
      rd(ra[i], d, r);
      check("reset value", d, rv[i]);
    end
    repeat (30) @(posedge clock);
    rd(OFS_COUNT, d, r);
    check("idle counts", d, 32'h0);
    check("idle pin", {31'h0, carrier_out_pin}, 32'h0);
    rd(6'h28, d, r);
    check("unmapped read", {30'h0, r}, {30'h0, RESP_SLVERR});
    wr(6'h3c, 32'h1, r);
    check("unmapped write", {30'h0, r}, {30'h0, RESP_SLVERR});
    put(OFS_LOW_CMP, LOW_N);
    put(OFS_HIGH_CMP, HIGH_M);
    put(OFS_CARRIER, 32'h1);
    put(OFS_PC_CMP, 32'h4);
    put(OFS_CTRL, 32'h7);
    repeat (100) @(posedge clock);
    check("high width", {16'h0, led_high}, HIGH_M + 32'h1);
    check("low width", {16'h0, led_low}, LOW_N + 32'h1);
    rd(OFS_STATUS, d, r);
    check("carrier match", d & 32'h1, 32'h1);
    check("irq masked", {31'h0, irq}, 32'h0);
    put(OFS_IRQ_EN, 32'h1);
    check("irq raised", {31'h0, irq}, 32'h1);
    put(OFS_HIGH_CMP, HIGH_L);
    repeat (100) @(posedge clock);
    check("new high width", {16'h0, led_high}, HIGH_L + 32'h1);
    check("low kept", {16'h0, led_low}, LOW_N + 32'h1);
    put(OFS_CTRL, 32'h3);
    repeat (3) @(posedge clock);
    snap = led_count;
    repeat (100) @(posedge clock);
    check("gated pulses", {16'h0, led_count - snap}, 32'h0);
    put(OFS_CTRL, 32'h0);
    repeat (3) @(posedge clock);
    check("stopped pin", {31'h0, carrier_out_pin}, 32'h0);
    put(OFS_IRQ_CLR, 32'h3);
    rd(OFS_STATUS, d, r);
    check("status cleared", d, 32'h0);
    check("irq cleared", {31'h0, irq}, 32'h0);
    // Load a cleared master first so the burst starts dark.
    put(OFS_CARRIER, 32'h0);
    put(OFS_CTRL, 32'h3);
    wait_bit(OFS_CARRIER, CARR_MST, 1'b0);
    put(OFS_CTRL, 32'h0);
    put(OFS_LOW_CMP, 32'hf);
    put(OFS_HIGH_CMP, 32'hf);
    put(OFS_PC_SEL, {29'h0, PCSEL_CARRIER});
    put(OFS_PC_CMP, 32'h2);
    put(OFS_CARRIER, 32'h1);
    put(OFS_CTRL, 32'h7);
    wait_bit(OFS_CARRIER, CARR_MST, 1'b1);
    snap = led_count;
    put(OFS_CARRIER, 32'h0);
    wait_bit(OFS_CARRIER, CARR_MST, 1'b0);
    repeat (40) @(posedge clock);
    check("burst pulses", {16'h0, led_count - snap}, 32'h3);
    check("last pulse width", {16'h0, led_high}, 32'h10);
    check("burst low width", {16'h0, led_low}, 32'h10);
    stop_test();
  end
endmodule
